// ---- logic/master_interrupt_pending_map.svh ----
/*
 * Register offsets, field positions, reset values and decode constants of the
 * master interrupt pending block.
 * Assumes byte addresses on a 12-bit register port with 32-bit data.
 */
`ifndef MASTER_INTERRUPT_PENDING_MAP_SVH
`define MASTER_INTERRUPT_PENDING_MAP_SVH

`define ADDR_W 12
`define OFF_PENDING 12'h000
`define OFF_MASK 12'h004
`define OFF_FIELD_SELECT 12'h008
`define OFF_PORT_MODE 12'h00c
`define OFF_RX_SIG_BASE 12'h040
`define OFF_UNDERRUN_BASE 12'h080
`define RX_SIG_BLOCK 7'h02
`define UNDERRUN_BLOCK 6'h02

`define BIT_MAC 27
`define BIT_QUEUE 26
`define BIT_CTRL_WORD 25
`define BIT_REQ_PIN 24
`define LSB_TX_SIG 16
`define LSB_UNDERRUN 8
`define LSB_RX_SIG 0

`define RST_PENDING 32'h0000_0000
`define RST_MASK 32'h0fff_ffff
`define RST_FIELD_SELECT 4'hf
`define RST_PORT_MODE 16'h0000
`define IMPL_BITS 32'h0fff_ffff
`define MODE_ASYNC 2'h0

`endif

// ---- logic/master_interrupt_pending_pkg.sv ----
/*
 * Types shared by the master interrupt pending block and its flag bank.
 * Assumes the map header for all numeric constants.
 */
package master_interrupt_pending_pkg;
    typedef logic [31:0] word_t;
    typedef logic [2:0] port_idx_t;
    typedef logic [4:0] slot_idx_t;
    typedef logic [7:0] port_vec_t;
endpackage : master_interrupt_pending_pkg

// ---- logic/flag_bank_if.sv ----
/*
 * Connection between the top block and one per-port per-timeslot flag bank.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/100ps
interface flag_bank_if;
    import master_interrupt_pending_pkg::*;
    logic ev_valid;
    port_idx_t ev_port;
    slot_idx_t ev_slot;
    logic wr;
    logic rd;
    port_idx_t sel_port;
    word_t wdata;
    word_t rdata;
    port_vec_t summary;
    modport owner (output ev_valid, ev_port, ev_slot, wr, rd, sel_port, wdata,
                   input rdata, summary);
    modport bank (input ev_valid, ev_port, ev_slot, wr, rd, sel_port, wdata,
                  output rdata, summary);
endinterface : flag_bank_if

// ---- logic/flag_bank.sv ----
/*
 * Eight 32-bit per-timeslot change words, write one to clear, with one
 * summary bit per port and registered read data.
 * Assumes a single owner on mclk with synchronous active-high reset.
 */
`timescale 1ns/100ps
module flag_bank
    import master_interrupt_pending_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    flag_bank_if.bank bus
);
    word_t flags_q [8];
    word_t rdata_q;

    always_ff @(posedge mclk) begin
        for (int p = 0; p < 8; p++) begin
            word_t set_v;
            word_t clr_v;
            set_v = '0;
            clr_v = '0;
            if (bus.ev_valid && bus.ev_port == port_idx_t'(p)) begin
                set_v[bus.ev_slot] = 1'b1;
            end
            if (bus.wr && bus.sel_port == port_idx_t'(p)) begin
                clr_v = bus.wdata;
            end
            // New events win over a clear in the same cycle
            if (sys_rst) begin
                flags_q[p] <= '0;
            end else begin
                flags_q[p] <= (flags_q[p] & ~clr_v) | set_v;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (bus.rd) begin
            rdata_q <= flags_q[bus.sel_port];
        end
    end

    assign bus.rdata = rdata_q;

    always_comb begin
        for (int p = 0; p < 8; p++) begin
            bus.summary[p] = |flags_q[p];
        end
    end

    bank_event_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE9]
        bus.ev_valid |=> flags_q[$past(bus.ev_port)][$past(bus.ev_slot)])
        else $error("timeslot flag not set by its event");
endmodule : flag_bank

// ---- logic/master_interrupt_pending.sv ----
/*
 * Master interrupt pending register with mask, field select, port modes,
 * request-pin change detection and two second-level per-timeslot banks.
 * Assumes event inputs on mclk, request pins asynchronous, register port
 * strobes one cycle long and read data taken one cycle after the read strobe.
 */
// Behaviour
// [RULE1] A MAC event sets pending bit 27.
// [RULE2] A host queue or pool threshold crossing sets pending bit 26.
// [RULE3] A change of the L, R, M or fragment field in any bundle sets pending bit 25.
// [RULE4] Only fields enabled in the field select register can raise bit 25.
// [RULE5] A request pin level change sets bit 24 only for ports in async serial mode 00.
// [RULE6] Bits 23 to 16 flag a transmit signaling change of ports 8 to 1.
// [RULE7] Bits 15 to 8 flag a jitter buffer underrun of ports 8 to 1.
// [RULE8] Bits 7 to 0 flag a receive signaling table change of ports 8 to 1.
// [RULE9] Each underrun bit summarises that port's per-timeslot underrun word.
// [RULE10] Each receive signaling bit summarises that port's per-timeslot change word.
// [RULE11] Pending bits latch at one, a written one clears and a written zero keeps.
// [RULE12] A mask bit at one blocks its pending bit from the interrupt, zero passes it.
// [RULE13] Only one, two, four or eight ports exist and absent ports never set a bit.
// [RULE14] The interrupt is high while any pending bit with a clear mask bit is set.
// [RULE15] Software writes zero to the upper four bits and pending reads zero after reset.
`timescale 1ns/100ps
`include "master_interrupt_pending_map.svh"
module master_interrupt_pending
    import master_interrupt_pending_pkg::*;
#(
    parameter int PORTS = 8
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic mac_event,
    input wire logic queue_threshold_event,
    input wire logic [3:0] control_word_change,
    input wire logic [7:0] line_request_pin,
    input wire logic [7:0] tx_sig_change,
    input wire logic underrun_valid,
    input wire logic [2:0] underrun_port,
    input wire logic [4:0] underrun_slot,
    input wire logic rx_sig_valid,
    input wire logic [2:0] rx_sig_port,
    input wire logic [4:0] rx_sig_slot
);
    function automatic port_vec_t present_ports(input int n);
        port_vec_t v;
        v = '0;
        for (int i = 0; i < 8; i++) begin
            v[i] = (i < n);
        end
        return v;
    endfunction : present_ports

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction : hit

    localparam port_vec_t PRESENT = present_ports(PORTS);

    word_t pending_q;
    word_t mask_q;
    logic [3:0] field_select_q;
    logic [15:0] port_mode_q;
    word_t rdata_q;
    logic from_rx_q;
    logic from_underrun_q;
    port_vec_t pin_s1_q;
    port_vec_t pin_s2_q;
    port_vec_t pin_s3_q;
    port_vec_t pin_level_q;
    port_vec_t async_port;
    port_vec_t pin_change;
    word_t set_vec;
    logic ctrl_word_hit;
    logic rx_sel;
    logic underrun_sel;
    port_idx_t rx_idx;
    port_idx_t underrun_idx;

    flag_bank_if rx_if ();
    flag_bank_if underrun_if ();

    flag_bank rx_bank (
        .mclk (mclk),
        .sys_rst (sys_rst),
        .bus (rx_if.bank)
    );

    flag_bank underrun_bank (
        .mclk (mclk),
        .sys_rst (sys_rst),
        .bus (underrun_if.bank)
    );

    assign rx_sel = reg_addr[11:5] == `RX_SIG_BLOCK;
    assign rx_idx = reg_addr[4:2];
    assign underrun_sel = reg_addr[11:6] == `UNDERRUN_BLOCK && reg_addr[2] == 1'b0;
    assign underrun_idx = reg_addr[5:3];

    // Absent ports never feed their banks
    assign rx_if.ev_valid = rx_sig_valid && PRESENT[rx_sig_port]; // [RULE13]
    assign rx_if.ev_port = rx_sig_port;
    assign rx_if.ev_slot = rx_sig_slot;
    assign rx_if.wr = reg_wr && rx_sel;
    assign rx_if.rd = reg_rd && rx_sel;
    assign rx_if.sel_port = rx_idx;
    assign rx_if.wdata = reg_wdata;

    assign underrun_if.ev_valid = underrun_valid && PRESENT[underrun_port]; // [RULE13]
    assign underrun_if.ev_port = underrun_port;
    assign underrun_if.ev_slot = underrun_slot;
    assign underrun_if.wr = reg_wr && underrun_sel;
    assign underrun_if.rd = reg_rd && underrun_sel;
    assign underrun_if.sel_port = underrun_idx;
    assign underrun_if.wdata = reg_wdata;

    // Request pin synchroniser, change counted once stages two and three agree
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= line_request_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_level_q <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) begin
                    pin_level_q[i] <= pin_s3_q[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            async_port[i] = port_mode_q[2*i +: 2] == `MODE_ASYNC; // [RULE5]
            pin_change[i] = pin_s2_q[i] == pin_s3_q[i] && pin_s3_q[i] != pin_level_q[i];
        end
    end

    assign ctrl_word_hit = |(control_word_change & field_select_q); // [RULE4]

    always_comb begin
        set_vec = '0;
        set_vec[`BIT_MAC] = mac_event; // [RULE1]
        set_vec[`BIT_QUEUE] = queue_threshold_event; // [RULE2]
        set_vec[`BIT_CTRL_WORD] = ctrl_word_hit; // [RULE3]
        set_vec[`BIT_REQ_PIN] = |(pin_change & async_port & PRESENT); // [RULE5] [RULE13]
        set_vec[`LSB_TX_SIG +: 8] = tx_sig_change & PRESENT; // [RULE6] [RULE13]
        set_vec[`LSB_UNDERRUN +: 8] = underrun_if.summary & PRESENT; // [RULE7] [RULE9]
        set_vec[`LSB_RX_SIG +: 8] = rx_if.summary & PRESENT; // [RULE8] [RULE10]
    end

    // Sticky pending bits, set wins over a same-cycle clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pending_q <= `RST_PENDING; // [RULE15]
        end else if (reg_wr && hit(reg_addr, `OFF_PENDING)) begin
            pending_q <= ((pending_q & ~reg_wdata) | set_vec) & `IMPL_BITS; // [RULE11]
        end else begin
            pending_q <= (pending_q | set_vec) & `IMPL_BITS; // [RULE11]
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mask_q <= `RST_MASK;
        end else if (reg_wr && hit(reg_addr, `OFF_MASK)) begin
            mask_q <= reg_wdata & `IMPL_BITS;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            field_select_q <= `RST_FIELD_SELECT;
        end else if (reg_wr && hit(reg_addr, `OFF_FIELD_SELECT)) begin
            field_select_q <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            port_mode_q <= `RST_PORT_MODE;
        end else if (reg_wr && hit(reg_addr, `OFF_PORT_MODE)) begin
            port_mode_q <= reg_wdata[15:0];
        end
    end

    // Local read data; bank reads come from the banks' own registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= '0;
            from_rx_q <= 1'b0;
            from_underrun_q <= 1'b0;
        end else begin
            from_rx_q <= reg_rd && rx_sel;
            from_underrun_q <= reg_rd && underrun_sel;
            if (reg_rd) begin
                case (reg_addr)
                    `OFF_PENDING: rdata_q <= pending_q;
                    `OFF_MASK: rdata_q <= mask_q;
                    `OFF_FIELD_SELECT: rdata_q <= {28'h0000000, field_select_q};
                    `OFF_PORT_MODE: rdata_q <= {16'h0000, port_mode_q};
                    default: rdata_q <= '0;
                endcase
            end else begin
                rdata_q <= '0;
            end
        end
    end

    always_comb begin
        if (from_rx_q) begin
            reg_rdata = rx_if.rdata;
        end else if (from_underrun_q) begin
            reg_rdata = underrun_if.rdata;
        end else begin
            reg_rdata = rdata_q;
        end
    end

    assign irq = |(pending_q & ~mask_q); // [RULE12] [RULE14]

    sequence pend_clear_s;
        reg_wr && hit(reg_addr, `OFF_PENDING) && reg_wdata[`BIT_MAC] && !mac_event;
    endsequence

    mac_event_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE1]
        mac_event |=> pending_q[`BIT_MAC])
        else $error("mac event did not set its pending bit");
    queue_event_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE2]
        queue_threshold_event |=> pending_q[`BIT_QUEUE])
        else $error("queue event did not set its pending bit");
    field_select_gate_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE3]
        (|(control_word_change & field_select_q)) |=> pending_q[`BIT_CTRL_WORD])
        else $error("selected control word change not flagged");
    field_block_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE4]
        !pending_q[`BIT_CTRL_WORD] && !(|(control_word_change & field_select_q))
        |=> !pending_q[`BIT_CTRL_WORD])
        else $error("unselected control word change flagged");
    pin_mode_gate_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
        !pending_q[`BIT_REQ_PIN] && !(|(pin_change & async_port & PRESENT))
        |=> !pending_q[`BIT_REQ_PIN])
        else $error("request pin bit set without async port change");
    tx_sig_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE6]
        (tx_sig_change & PRESENT) != 8'h00
        |=> (pending_q[`LSB_TX_SIG +: 8] & $past(tx_sig_change & PRESENT))
            == $past(tx_sig_change & PRESENT))
        else $error("tx signaling change not flagged on its port bit");
    underrun_summary_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE7]
        underrun_if.ev_valid |=> ##1 pending_q[`LSB_UNDERRUN + 32'($past(underrun_port, 2))])
        else $error("underrun did not reach its port pending bit");
    rx_summary_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE8]
        rx_if.ev_valid |=> ##1 pending_q[`LSB_RX_SIG + 32'($past(rx_sig_port, 2))])
        else $error("rx signaling change did not reach its pending bit");
    w1c_clear_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
        pend_clear_s |=> !pending_q[`BIT_MAC])
        else $error("write one did not clear the pending bit");
    zero_write_keep_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
        reg_wr && hit(reg_addr, `OFF_PENDING) && !reg_wdata[`BIT_QUEUE]
        && pending_q[`BIT_QUEUE] |=> pending_q[`BIT_QUEUE])
        else $error("write zero changed a pending bit");
    absent_port_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE13]
        (pending_q[`LSB_TX_SIG +: 8] & ~PRESENT) == 8'h00)
        else $error("absent port pending bit set");
    // Register port and interrupt checks
    sequence pend_write_s;
        reg_wr && hit(reg_addr, `OFF_PENDING);
    endsequence

    sequence mask_write_s;
        reg_wr && hit(reg_addr, `OFF_MASK);
    endsequence

    irq_level_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE12]
        mask_write_s ##0 ((reg_wdata & `IMPL_BITS) == `IMPL_BITS) |=> !irq)
        else $error("fully masked pending bits still raise the interrupt");
    irq_unmask_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE14]
        mask_write_s ##0 ((pending_q & ~reg_wdata & `IMPL_BITS) != 32'h0) |=> irq)
        else $error("unmasked pending bit did not raise the interrupt");
    irq_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE14]
        !irq && set_vec == 32'h0 && !(reg_wr && hit(reg_addr, `OFF_MASK)) |=> !irq)
        else $error("interrupt rose without an event or unmask");
    mask_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE12]
        mask_write_s |=> mask_q == ($past(reg_wdata) & `IMPL_BITS))
        else $error("mask write not taken");

    mac_set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
        pend_write_s ##0 (reg_wdata[`BIT_MAC] && mac_event) |=> pending_q[`BIT_MAC])
        else $error("mac event lost to a same cycle clear");
    pending_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE11]
        reg_rd && hit(reg_addr, `OFF_PENDING) |=> reg_rdata == $past(pending_q))
        else $error("pending read returned a stale value");
    reserved_zero_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE15]
        pending_q[31:28] == 4'h0 && mask_q[31:28] == 4'h0)
        else $error("reserved bits not zero");
    field_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE4]
        reg_wr && hit(reg_addr, `OFF_FIELD_SELECT) |=> field_select_q == $past(reg_wdata[3:0]))
        else $error("field select write not taken");
    port_mode_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
        reg_wr && hit(reg_addr, `OFF_PORT_MODE) |=> port_mode_q == $past(reg_wdata[15:0]))
        else $error("port mode write not taken");

    // Request pin path checks
    async_pin_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
        (pin_change & async_port & PRESENT) != 8'h00 |=> pending_q[`BIT_REQ_PIN])
        else $error("async request pin change not flagged");
    pin_settle_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE5]
        1'b1 |=> ((pin_level_q ^ $past(pin_level_q)) & $past(pin_s2_q ^ pin_s3_q)) == 8'h00)
        else $error("request pin level moved before its stages agreed");

    // Bank summary checks
    underrun_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE9]
        (underrun_if.summary & PRESENT) != 8'h00
        |=> (pending_q[`LSB_UNDERRUN +: 8] & $past(underrun_if.summary & PRESENT))
            == $past(underrun_if.summary & PRESENT))
        else $error("nonzero underrun word did not hold its pending bit");
    rx_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE10]
        (rx_if.summary & PRESENT) != 8'h00
        |=> (pending_q[`LSB_RX_SIG +: 8] & $past(rx_if.summary & PRESENT))
            == $past(rx_if.summary & PRESENT))
        else $error("nonzero rx signaling word did not hold its pending bit");
    absent_bank_a: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE13]
        (pending_q[`LSB_UNDERRUN +: 8] & ~PRESENT) == 8'h00
        && (pending_q[`LSB_RX_SIG +: 8] & ~PRESENT) == 8'h00)
        else $error("absent port bank bit set");

    reset_clear_a: assert property (@(posedge mclk) // [RULE15]
        sys_rst |=> pending_q == 32'h0000_0000 && !irq)
        else $error("pending not zero after reset");
endmodule : master_interrupt_pending

// ---- testbench/master_interrupt_pending_test.sv ----
/*
 * Self-checking bench for the master interrupt pending block, four ports built.
 * Assumes the map header constants and the register port timing of the block.
 */
`timescale 1ns/100ps
`include "master_interrupt_pending_map.svh"
module master_interrupt_pending_test;
    import master_interrupt_pending_pkg::*;
    localparam int PORTS = 4;
    logic mclk;
    logic sys_rst;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic irq;
    logic mac_event;
    logic queue_threshold_event;
    logic [3:0] control_word_change;
    logic [7:0] line_request_pin;
    logic [7:0] tx_sig_change;
    logic underrun_valid;
    logic [2:0] underrun_port;
    logic [4:0] underrun_slot;
    logic rx_sig_valid;
    logic [2:0] rx_sig_port;
    logic [4:0] rx_sig_slot;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    master_interrupt_pending #(.PORTS(PORTS)) master_interrupt_pending_i (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .mac_event(mac_event), .queue_threshold_event(queue_threshold_event),
        .control_word_change(control_word_change), .line_request_pin(line_request_pin),
        .tx_sig_change(tx_sig_change), .underrun_valid(underrun_valid),
        .underrun_port(underrun_port), .underrun_slot(underrun_slot),
        .rx_sig_valid(rx_sig_valid), .rx_sig_port(rx_sig_port), .rx_sig_slot(rx_sig_slot)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic stop_test;
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // Hang guard, far above the roughly 165 cycles the scenarios need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic check(input word_t seen, input word_t exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic reg_write(input logic [11:0] a, input word_t d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [11:0] a, output word_t d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic expect_reg(input logic [11:0] a, input word_t exp);
        word_t d;
        reg_read(a, d);
        check(d, exp);
    endtask : expect_reg

    task automatic reset_values;
        expect_reg(`OFF_PENDING, `RST_PENDING);
        expect_reg(`OFF_MASK, `RST_MASK);
        expect_reg(`OFF_FIELD_SELECT, {28'h0, `RST_FIELD_SELECT});
        expect_reg(`OFF_PORT_MODE, {16'h0, `RST_PORT_MODE});
        expect_reg(12'h300, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask : reset_values

    task automatic events_and_mask;
        word_t all;
        all = (32'h1 << `BIT_MAC) | (32'h1 << `BIT_QUEUE) | (32'h0f << `LSB_TX_SIG);
        @(posedge mclk);
        mac_event <= 1'b1;
        queue_threshold_event <= 1'b1;
        tx_sig_change <= 8'hff;
        @(posedge mclk);
        mac_event <= 1'b0;
        queue_threshold_event <= 1'b0;
        tx_sig_change <= 8'h00;
        tick(2);
        expect_reg(`OFF_PENDING, all);
        check({31'h0, irq}, 32'h0);
        reg_write(`OFF_MASK, `IMPL_BITS & ~(32'h1 << `BIT_MAC));
        check({31'h0, irq}, 32'h1);
        reg_write(`OFF_PENDING, 32'h0);
        expect_reg(`OFF_PENDING, all);
        reg_write(`OFF_PENDING, 32'h1 << `BIT_MAC);
        check({31'h0, irq}, 32'h0);
        expect_reg(`OFF_PENDING, all & ~(32'h1 << `BIT_MAC));
        reg_write(`OFF_PENDING, `IMPL_BITS);
        reg_write(`OFF_MASK, `RST_MASK);
        expect_reg(`OFF_PENDING, 32'h0);
        // Event and clear of the same bit in one cycle
        @(posedge mclk);
        mac_event <= 1'b1;
        reg_wr <= 1'b1;
        reg_addr <= `OFF_PENDING;
        reg_wdata <= 32'h1 << `BIT_MAC;
        @(posedge mclk);
        mac_event <= 1'b0;
        reg_wr <= 1'b0;
        expect_reg(`OFF_PENDING, 32'h1 << `BIT_MAC);
        check({31'h0, irq}, 32'h0);
        reg_write(`OFF_PENDING, 32'h1 << `BIT_MAC);
        expect_reg(`OFF_PENDING, 32'h0);
    endtask : events_and_mask

    task automatic field_select;
        for (int f = 0; f < 4; f++) begin
            reg_write(`OFF_FIELD_SELECT, 32'h1 << f);
            @(posedge mclk);
            control_word_change <= ~(4'h1 << f);
            @(posedge mclk);
            control_word_change <= 4'h0;
            expect_reg(`OFF_PENDING, 32'h0);
            @(posedge mclk);
            control_word_change <= 4'h1 << f;
            @(posedge mclk);
            control_word_change <= 4'h0;
            expect_reg(`OFF_PENDING, 32'h1 << `BIT_CTRL_WORD);
            reg_write(`OFF_PENDING, 32'h1 << `BIT_CTRL_WORD);
        end
    endtask : field_select

    task automatic request_pins;
        // Port 2 leaves async mode, port 1 stays in it
        reg_write(`OFF_PORT_MODE, 32'h4);
        @(posedge mclk);
        line_request_pin <= 8'h02;
        tick(8);
        expect_reg(`OFF_PENDING, 32'h0);
        @(posedge mclk);
        line_request_pin <= 8'h03;
        tick(8);
        expect_reg(`OFF_PENDING, 32'h1 << `BIT_REQ_PIN);
        reg_write(`OFF_PENDING, 32'h1 << `BIT_REQ_PIN);
        expect_reg(`OFF_PENDING, 32'h0);
    endtask : request_pins

    task automatic bank_summaries;
        @(posedge mclk);
        underrun_valid <= 1'b1;
        underrun_port <= 3'h1;
        underrun_slot <= 5'h05;
        rx_sig_valid <= 1'b1;
        rx_sig_port <= 3'h2;
        rx_sig_slot <= 5'h1f;
        @(posedge mclk);
        underrun_port <= 3'h4;
        underrun_slot <= 5'h00;
        rx_sig_port <= 3'h7;
        @(posedge mclk);
        underrun_valid <= 1'b0;
        rx_sig_valid <= 1'b0;
        tick(2);
        expect_reg(`OFF_UNDERRUN_BASE + 12'h008, 32'h0000_0020);
        expect_reg(`OFF_RX_SIG_BASE + 12'h008, 32'h8000_0000);
        expect_reg(`OFF_PENDING, (32'h1 << 9) | (32'h1 << 2));
        reg_write(`OFF_PENDING, 32'h0000_0204);
        tick(2);
        expect_reg(`OFF_PENDING, 32'h0000_0204);
        reg_write(`OFF_UNDERRUN_BASE + 12'h008, 32'h0000_0020);
        reg_write(`OFF_RX_SIG_BASE + 12'h008, 32'h8000_0000);
        reg_write(`OFF_PENDING, 32'h0000_0204);
        tick(2);
        expect_reg(`OFF_PENDING, 32'h0);
        expect_reg(`OFF_UNDERRUN_BASE + 12'h008, 32'h0);
    endtask : bank_summaries

    initial begin
        sys_rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mac_event = 1'b0;
        queue_threshold_event = 1'b0;
        control_word_change = 4'h0;
        line_request_pin = 8'h00;
        tx_sig_change = 8'h00;
        underrun_valid = 1'b0;
        underrun_port = 3'h0;
        underrun_slot = 5'h00;
        rx_sig_valid = 1'b0;
        rx_sig_port = 3'h0;
        rx_sig_slot = 5'h00;
        tick(20);
        sys_rst <= 1'b0;
        reset_values();
        events_and_mask();
        field_select();
        request_pins();
        bank_summaries();
        stop_test();
    end
endmodule : master_interrupt_pending_test
